// ==== core/rsgp_pkg.sv ====
/*
 * rsgp_pkg: register map, field layout, reset values and timing constants
 * for the reset, strap and general-pin block.
 * Assumes a 200 MHz register clock and a 32-bit AHB-Lite register bus.
 */
package rsgp_pkg;
    // clock and reset timing
    localparam int unsigned CLK_MHZ         = 200;
    localparam int unsigned RST_MIN_LOW_US  = 1;
    localparam int unsigned RST_MIN_CYCLES  = RST_MIN_LOW_US * CLK_MHZ;
    localparam logic [7:0]  RST_CNT_MAX     = 8'(RST_MIN_CYCLES - 1);

    // register byte offsets
    localparam logic [7:0] OFS_MAIN_CONFIG_TWO = 8'h00;
    localparam logic [7:0] OFS_GP_CONFIG_ONE   = 8'h04;
    localparam logic [7:0] OFS_GP_CONFIG_TWO   = 8'h08;
    localparam logic [7:0] OFS_GP_STATUS       = 8'h0C;
    localparam logic [7:0] OFS_GP_INT_MASK     = 8'h10;
    localparam logic [7:0] OFS_STRAP_STATUS    = 8'h14;

    // main_config_two: reference_input_select in bits 1:0
    localparam int unsigned REF_SEL_LSB = 0;
    localparam logic [1:0]  REF_SEL_XTAL = 2'h1;
    localparam logic [1:0]  REF_SEL_EXT  = 2'h2;
    localparam logic [1:0]  REF_SEL_RST  = 2'h1;

    // general_pin_config_one: pin 0 in 3:0, pin 1 in 7:4
    // general_pin_config_two: pin_two_function_field 3:0, pin_three_function_field 7:4
    // each nibble: bit0 output enable, bit1 output level, bit2 latch on rise, bit3 latch on fall
    localparam int unsigned FLD_W     = 4;
    localparam int unsigned FLD_OE    = 0;
    localparam int unsigned FLD_LVL   = 1;
    localparam int unsigned FLD_RISE  = 2;
    localparam int unsigned FLD_FALL  = 3;
    localparam logic [7:0]  GP_CFG_RST = 8'h00;

    // general_pin_status: live levels 3:0, latched 7:4
    localparam int unsigned NUM_GP       = 4;
    localparam int unsigned ST_LATCH_LSB = 4;

    // strap status: config select 2:0, test 3, output count code 4
    localparam int unsigned STRAP_TEST_BIT = 3;
    localparam int unsigned STRAP_TEN_BIT  = 4;

    // output clocks present: bit n is output clock n+1
    localparam logic [9:0] OUT_CLK_ALL = 10'h3FF;
    localparam logic [9:0] OUT_CLK_SIX = 10'h1AD;   // clocks 2, 5, 7 and 10 left out

    // bus constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] ZERO_WORD    = 32'h00000000;

    typedef enum logic [1:0] {
        RSGP_ST_HOLD = 2'b00,
        RSGP_ST_RUN  = 2'b01
    } rsgp_state_t;
endpackage

// ==== core/rsgp_top.sv ====
/*
 * rsgp_top: reset hold, strap capture at reset release, shared-pin change
 * over to four general pins, reference input select and output-clock presence flags.
 * Assumes one 200 MHz clock, an AHB-Lite master as the only bus master and
 * a board that presents strap levels while reset_pin_low is low.
 */
// Register access over AHB-Lite and the register addresses were decided locally.
// Operation
// (RQ1) Select field 01 runs reference pins as crystal oscillator.
// (RQ2) Select field 10 takes external clock on reference pin a.
// (RQ3) Low reset pin forces all logic to defaults asynchronously; the diagnostic rst_low_cnt counts while the pin is low instead.
// (RQ4) Device stays in reset while pin low, runs after release.
// (RQ5) Board holds reset pin low at least 1 us.
// (RQ6) Three config-select straps sampled at reset rising edge.
// (RQ7) After reset, strap pins become general pins 0, 1, 2.
// (RQ8) Pins 0,1 follow config one; pin 2 follows config two field.
// (RQ9) Status register shows live and latched bit per pin.
// (RQ10) Test strap sampled at reset rising edge.
// (RQ11) Sampled-high test strap enters factory test mode.
// (RQ12) Test pin becomes general pin 3 under config two field.
// (RQ13) Six-output variant omits output clocks 2, 5, 7, 10.
// (RQ14) Latched status bits stay set until software clears them.
`timescale 1ns/100ps
module rsgp_top
    import rsgp_pkg::*;
#(
    parameter bit TEN_OUTPUTS = 1'b1
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        reset_pin_low_i,
    input  wire logic [3:0]  gp_pin_i,
    output logic      [3:0]  gp_pin_o,
    output logic      [3:0]  gp_pin_oe_n_o,
    output logic             xtal_drive_en_o,
    output logic             ext_clk_en_o,
    output logic      [9:0]  out_clk_present_o,
    output logic      [2:0]  config_select_strap_o,
    output logic             factory_test_o,
    output logic             running_o,
    output logic             irq_o,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o
);
    import rsgp_pkg::*;

    rsgp_state_t state;
    logic        in_reset;
    logic [7:0]  main_config_two;
    logic [7:0]  general_pin_config_one;
    logic [7:0]  general_pin_config_two;
    logic [3:0]  gp_latched;
    logic [3:0]  gp_int_mask;
    logic [3:0]  gp_prev;
    logic [3:0]  gp_event;
    logic [3:0]  gp_keep;
    logic [15:0] gp_cfg;
    logic [7:0]  dp_addr;
    logic        dp_write;
    logic        dp_read;
    logic        st_read_clr;
    logic [7:0]  rst_low_cnt;

    // pin reset treated as asynchronous: combined with the system reset
    assign in_reset = rst_i | ~reset_pin_low_i;

    // state: hold while reset pin low, run after release
    // (RQ4) hold then run
    always_ff @(posedge ref_clk_i or posedge in_reset) begin
        if (in_reset) begin
            state <= RSGP_ST_HOLD;
        end else begin
            case (state)
                RSGP_ST_HOLD: state <= RSGP_ST_RUN;
                default:      state <= RSGP_ST_RUN;
            endcase
        end
    end
    assign running_o = (state == RSGP_ST_RUN);

    // strap capture on the first edge after release; pins still strapped then
    // (RQ6) config select capture
    always_ff @(posedge ref_clk_i or posedge in_reset) begin
        if (in_reset) begin
            config_select_strap_o <= 3'h0;
            factory_test_o        <= 1'b0;
        end else if (state == RSGP_ST_HOLD) begin
            config_select_strap_o <= gp_pin_i[2:0];
            // (RQ10) test strap sample
            // (RQ11) factory test entry
            factory_test_o        <= gp_pin_i[3];
        end
    end

    // reset low-time counter, diagnostic only; board keeps the 1 us minimum
    // (RQ5) low time check
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rst_low_cnt <= 8'h00;
        end else if (!reset_pin_low_i) begin
            if (rst_low_cnt != RST_CNT_MAX) begin
                rst_low_cnt <= rst_low_cnt + 8'h01;
            end
        end else begin
            rst_low_cnt <= 8'h00;
        end
    end

    // reference input selection
    // (RQ1) crystal drive
    assign xtal_drive_en_o = running_o && (main_config_two[REF_SEL_LSB +: 2] == REF_SEL_XTAL);
    // (RQ2) external clock
    assign ext_clk_en_o    = running_o && (main_config_two[REF_SEL_LSB +: 2] == REF_SEL_EXT);

    // (RQ13) output clock presence
    assign out_clk_present_o = TEN_OUTPUTS ? OUT_CLK_ALL : OUT_CLK_SIX;

    // per-pin configuration nibbles, pin 0..3
    // (RQ8) config mapping
    assign gp_cfg = {general_pin_config_two, general_pin_config_one};

    // pin drivers: tri-stated in reset so straps are not fought
    genvar g;
    generate
        for (g = 0; g < NUM_GP; g++) begin : g_pin
            // (RQ7) straps become general pins
            // (RQ12) pin three general use
            assign gp_pin_o[g]      = gp_cfg[g*FLD_W + FLD_LVL];
            assign gp_pin_oe_n_o[g] = ~(running_o & gp_cfg[g*FLD_W + FLD_OE]);
            assign gp_event[g]      = running_o &
                ((gp_cfg[g*FLD_W + FLD_RISE] & gp_pin_i[g] & ~gp_prev[g]) |
                 (gp_cfg[g*FLD_W + FLD_FALL] & ~gp_pin_i[g] & gp_prev[g]));
        end
    endgenerate

    // previous level for edge detection
    always_ff @(posedge ref_clk_i or posedge in_reset) begin
        if (in_reset) begin
            gp_prev <= 4'h0;
        end else begin
            gp_prev <= gp_pin_i;
        end
    end

    // latched status: set wins over read-clear
    // (RQ14) sticky latch
    always_ff @(posedge ref_clk_i or posedge in_reset) begin
        if (in_reset) begin
            gp_latched <= 4'h0;
        end else if (st_read_clr) begin
            gp_latched <= gp_event;
        end else begin
            gp_latched <= gp_latched | gp_event;
        end
    end

    assign irq_o = |(gp_latched & gp_int_mask);

    // bits that must still be latched at the next edge; read by checks only
    assign gp_keep = gp_event | (gp_latched & ~{NUM_GP{st_read_clr}});

    // AHB-Lite address phase capture; always zero wait state
    always_ff @(posedge ref_clk_i or posedge in_reset) begin
        if (in_reset) begin
            dp_addr  <= 8'h00;
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
        end else if (hready_i) begin
            dp_addr  <= haddr_i[7:0];
            dp_write <= hsel_i && (htrans_i == HTRANS_NONSEQ) && hwrite_i;
            dp_read  <= hsel_i && (htrans_i == HTRANS_NONSEQ) && !hwrite_i;
        end else begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign st_read_clr = dp_read && (dp_addr == OFS_GP_STATUS);

    // (RQ3) async defaults
    always_ff @(posedge ref_clk_i or posedge in_reset) begin
        if (in_reset) begin
            main_config_two        <= {6'h00, REF_SEL_RST};
            general_pin_config_one <= GP_CFG_RST;
            general_pin_config_two <= GP_CFG_RST;
            gp_int_mask            <= 4'h0;
        end else if (dp_write) begin
            if (dp_addr == OFS_MAIN_CONFIG_TWO) begin
                main_config_two <= hwdata_i[7:0];
            end else if (dp_addr == OFS_GP_CONFIG_ONE) begin
                general_pin_config_one <= hwdata_i[7:0];
            end else if (dp_addr == OFS_GP_CONFIG_TWO) begin
                general_pin_config_two <= hwdata_i[7:0];
            end else if (dp_addr == OFS_GP_INT_MASK) begin
                gp_int_mask <= hwdata_i[3:0];
            end
        end
    end

    // read mux; unmapped offsets read zero
    // (RQ9) live and latched
    always_comb begin
        hrdata_o = ZERO_WORD;
        if (dp_addr == OFS_MAIN_CONFIG_TWO) begin
            hrdata_o = {24'h000000, main_config_two};
        end else if (dp_addr == OFS_GP_CONFIG_ONE) begin
            hrdata_o = {24'h000000, general_pin_config_one};
        end else if (dp_addr == OFS_GP_CONFIG_TWO) begin
            hrdata_o = {24'h000000, general_pin_config_two};
        end else if (dp_addr == OFS_GP_STATUS) begin
            hrdata_o = {24'h000000, gp_latched, gp_pin_i};
        end else if (dp_addr == OFS_GP_INT_MASK) begin
            hrdata_o = {28'h0000000, gp_int_mask};
        end else if (dp_addr == OFS_STRAP_STATUS) begin
            hrdata_o = {27'h0000000, TEN_OUTPUTS, factory_test_o, config_select_strap_o};
        end
    end

    // checks
    property p_strap_capture;
        @(posedge ref_clk_i) disable iff (in_reset)
        (state == RSGP_ST_HOLD) |=> (config_select_strap_o == $past(gp_pin_i[2:0]));
    endproperty
    a_strap_capture: assert property (p_strap_capture) else $error("strap not captured"); // RQ6

    property p_test_capture;
        @(posedge ref_clk_i) disable iff (in_reset)
        (state == RSGP_ST_HOLD) |=> (factory_test_o == $past(gp_pin_i[3]));
    endproperty
    a_test_capture: assert property (p_test_capture) else $error("test strap not captured"); // RQ10

    property p_straps_hold;
        @(posedge ref_clk_i) disable iff (in_reset)
        running_o |=> $stable(factory_test_o) && $stable(config_select_strap_o);
    endproperty
    a_straps_hold: assert property (p_straps_hold) else $error("strap changed while running"); // RQ11

    property p_xtal;
        @(posedge ref_clk_i) disable iff (in_reset)
        (running_o && main_config_two[1:0] == REF_SEL_XTAL) |-> xtal_drive_en_o && !ext_clk_en_o;
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal drive wrong"); // RQ1

    property p_ext;
        @(posedge ref_clk_i) disable iff (in_reset)
        (running_o && main_config_two[1:0] == REF_SEL_EXT) |-> ext_clk_en_o && !xtal_drive_en_o;
    endproperty
    a_ext: assert property (p_ext) else $error("external clock select wrong"); // RQ2

    property p_run_after_release;
        @(posedge ref_clk_i) disable iff (in_reset)
        (state == RSGP_ST_HOLD) |=> running_o;
    endproperty
    a_run_after_release: assert property (p_run_after_release) else $error("no run after release"); // RQ4

    property p_oe_pin0;
        @(posedge ref_clk_i) disable iff (in_reset)
        running_o |-> (gp_pin_oe_n_o[0] == !general_pin_config_one[FLD_OE])
                      && (gp_pin_oe_n_o[3] == !general_pin_config_two[FLD_W + FLD_OE]);
    endproperty
    a_oe_pin0: assert property (p_oe_pin0) else $error("pin enable mismatch"); // RQ8

    sequence s_keep;
        |gp_keep;
    endsequence
    property p_sticky;
        @(posedge ref_clk_i) disable iff (in_reset)
        s_keep |=> ((gp_latched & $past(gp_keep)) == $past(gp_keep));
    endproperty
    a_sticky: assert property (p_sticky) else $error("latched bit lost"); // RQ14

    property p_status_live;
        @(posedge ref_clk_i) disable iff (in_reset)
        (dp_read && dp_addr == OFS_GP_STATUS) |-> hrdata_o[3:0] == gp_pin_i;
    endproperty
    a_status_live: assert property (p_status_live) else $error("live status wrong"); // RQ9

    property p_six_out;
        @(posedge ref_clk_i) disable iff (in_reset)
        !TEN_OUTPUTS |-> (out_clk_present_o[1] == 1'b0) && (out_clk_present_o[4] == 1'b0)
                         && (out_clk_present_o[6] == 1'b0) && (out_clk_present_o[9] == 1'b0)
                         && ($countones(out_clk_present_o) == 6);
    endproperty
    a_six_out: assert property (p_six_out) else $error("omitted outputs present"); // RQ13

    property p_ten_out;
        @(posedge ref_clk_i) disable iff (in_reset)
        TEN_OUTPUTS |-> (&out_clk_present_o);
    endproperty
    a_ten_out: assert property (p_ten_out) else $error("output clock missing"); // RQ13

    // the low time is the board's duty; the diagnostic counter only reports it
    sequence s_release;
        $rose(reset_pin_low_i);
    endsequence
    property p_rst_low_time;
        @(posedge ref_clk_i) disable iff (in_reset)
        s_release |-> (rst_low_cnt == RST_CNT_MAX);
    endproperty
    a_rst_low_time: assert property (p_rst_low_time) else $error("reset pin low too short"); // RQ5

    property p_read_clear;
        @(posedge ref_clk_i) disable iff (in_reset)
        st_read_clr |=> (gp_latched == $past(gp_event));
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status read did not clear"); // RQ14

    property p_irq_on_event;
        @(posedge ref_clk_i) disable iff (in_reset)
        (|(gp_event & gp_int_mask)) |=> irq_o;
    endproperty
    a_irq_on_event: assert property (p_irq_on_event) else $error("unmasked event without interrupt"); // RQ14

    property p_mask_write;
        @(posedge ref_clk_i) disable iff (in_reset)
        (dp_write && dp_addr == OFS_GP_INT_MASK) |=> (gp_int_mask == $past(hwdata_i[3:0]));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // RQ14

    property p_pins_float;
        @(posedge ref_clk_i) disable iff (in_reset)
        !running_o |-> (gp_pin_oe_n_o == '1);
    endproperty
    a_pins_float: assert property (p_pins_float) else $error("pin driven before run"); // RQ7

    property p_cfg_write;
        @(posedge ref_clk_i) disable iff (in_reset)
        (dp_write && dp_addr == OFS_GP_CONFIG_ONE) |=> (general_pin_config_one == $past(hwdata_i[7:0]));
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("pin config write lost"); // RQ8

    property p_ref_write;
        @(posedge ref_clk_i) disable iff (in_reset)
        (dp_write && dp_addr == OFS_MAIN_CONFIG_TWO) |=> (main_config_two == $past(hwdata_i[7:0]));
    endproperty
    a_ref_write: assert property (p_ref_write) else $error("reference select write lost"); // RQ1

    property p_pin_two_three;
        @(posedge ref_clk_i) disable iff (in_reset)
        running_o |-> (gp_pin_oe_n_o[2] == !general_pin_config_two[FLD_OE])
                      && (gp_pin_o[3] == general_pin_config_two[FLD_W + FLD_LVL]);
    endproperty
    a_pin_two_three: assert property (p_pin_two_three) else $error("pin two or three config wrong"); // RQ12

    property p_strap_status;
        @(posedge ref_clk_i) disable iff (in_reset)
        (dp_read && dp_addr == OFS_STRAP_STATUS) |-> (hrdata_o[STRAP_TEST_BIT] == factory_test_o)
                                                     && (hrdata_o[STRAP_TEN_BIT] == TEN_OUTPUTS);
    endproperty
    a_strap_status: assert property (p_strap_status) else $error("strap status read wrong"); // RQ11
endmodule

// ==== verification/rsgp_board_model.sv ====
/*
 * rsgp_board_model: board around the block, with the reset pin driver
 * and the strap and general pin levels.
 * Assumes one clock; the bench asks for a reset by a one-cycle request.
 */
`timescale 1ns/100ps
module rsgp_board_model (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_req_i,
    input  wire logic [3:0] board_lvl_i,
    input  wire logic [3:0] gp_pin_o,
    input  wire logic [3:0] gp_pin_oe_n_o,
    output logic            reset_pin_low_o = 1'b1,
    output logic      [3:0] gp_pin_i
);
    logic [7:0] low_cnt = 8'h00;

    always_ff @(posedge ref_clk_i) begin
        if (rst_req_i) begin
            reset_pin_low_o <= 1'b0;
            low_cnt         <= 8'hC7;
        end else if (low_cnt != 8'h00) begin
            low_cnt <= low_cnt - 8'h01;
        end else begin
            reset_pin_low_o <= 1'b1;
        end
    end

    // board strap levels
    // pin level: device drive wins, else board level, never left floating
    assign gp_pin_i = (gp_pin_oe_n_o & board_lvl_i) | (~gp_pin_oe_n_o & gp_pin_o);
endmodule

// ==== verification/tb_top.sv ====
/*
 * tb_top: register-level tests of the reset, strap and general-pin block.
 * Assumes the block answers every AHB-Lite transfer; board model drives pins.
 */
`timescale 1ns/100ps
module tb_top;
    import rsgp_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        rst_req   = 1'b0;
    logic [3:0]  board_lvl = 4'h5;
    logic        reset_pin_low, xtal_en, ext_en, running, irq, test_mode, hrdy, hresp;
    logic [3:0]  pin_in, pin_out, pin_oe_n;
    logic [9:0]  oc_present;
    logic [2:0]  straps;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, got;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    int          n_fail = 0;
    int          n_compared = 0;
    int          cycles = 0;

    rsgp_top dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reset_pin_low_i(reset_pin_low),
        .gp_pin_i(pin_in), .gp_pin_o(pin_out), .gp_pin_oe_n_o(pin_oe_n), .xtal_drive_en_o(xtal_en),
        .ext_clk_en_o(ext_en), .out_clk_present_o(oc_present), .config_select_strap_o(straps),
        .factory_test_o(test_mode), .running_o(running), .irq_o(irq), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp));

    rsgp_board_model board_u (.ref_clk_i(ref_clk_i), .rst_req_i(rst_req), .board_lvl_i(board_lvl),
        .gp_pin_o(pin_out), .gp_pin_oe_n_o(pin_oe_n), .reset_pin_low_o(reset_pin_low), .gp_pin_i(pin_in));

    always #2.5 ref_clk_i = ~ref_clk_i;

    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles needed
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // one transfer; read data taken at the data-phase edge, before updates land
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        htrans <= HTRANS_NONSEQ;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge ref_clk_i); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk_i); while (hrdy !== 1'b1);
        got = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, ZERO_WORD);
        chk(got, exp);
    endtask

    initial begin
        cyc(6);
        rst_i <= 1'b0;
        cyc(3);
        chk(32'(straps), 32'h5);
        chk(32'(test_mode), 32'h0);
        chk(32'(running), 32'h1);
        chk(32'(oc_present), 32'h3FF);
        chk(32'(pin_oe_n), 32'hF);
        rdc(OFS_MAIN_CONFIG_TWO, 32'h1);
        rdc(OFS_GP_CONFIG_ONE, 32'h0);
        rdc(OFS_GP_CONFIG_TWO, 32'h0);
        rdc(OFS_GP_STATUS, 32'h5);
        chk(32'(hresp), 32'h0);
        rdc(OFS_STRAP_STATUS, 32'h15);
        rdc(8'h20, 32'h0);
        wr(8'h20, 32'hFFFFFFFF);
        $display("test defaults done");

        chk(32'(xtal_en), 32'h1);
        chk(32'(ext_en), 32'h0);
        wr(OFS_MAIN_CONFIG_TWO, 32'h2);
        cyc(1);
        chk(32'(xtal_en), 32'h0);
        chk(32'(ext_en), 32'h1);
        wr(OFS_MAIN_CONFIG_TWO, 32'h1);
        $display("test reference select done");

        board_lvl <= 4'hA;
        wr(OFS_GP_CONFIG_ONE, 32'h13);
        wr(OFS_GP_CONFIG_TWO, 32'h13);
        cyc(1);
        chk(32'(pin_oe_n), 32'h0);
        chk(32'(pin_out), 32'h5);
        rdc(OFS_GP_STATUS, 32'h5);
        wr(OFS_GP_CONFIG_ONE, 32'h0);
        wr(OFS_GP_CONFIG_TWO, 32'h0);
        board_lvl <= 4'h5;
        $display("test general pins done");

        wr(OFS_GP_CONFIG_TWO, 32'h48);
        wr(OFS_GP_INT_MASK, 32'h8);
        ahb(1'b0, OFS_GP_STATUS, ZERO_WORD);
        board_lvl <= 4'h9;
        for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge ref_clk_i);
        cyc(3);
        chk(32'(irq), 32'h1);
        rdc(OFS_GP_STATUS, 32'hC9);
        cyc(1);
        chk(32'(irq), 32'h0);
        rdc(OFS_GP_STATUS, 32'h09);
        wr(OFS_GP_CONFIG_TWO, 32'h04);
        board_lvl <= 4'hD;
        cyc(6);
        chk(32'(irq), 32'h0);
        rdc(OFS_GP_STATUS, 32'h4D);
        $display("test latched events done");

        wr(OFS_GP_CONFIG_ONE, 32'h13);
        board_lvl <= 4'hA;
        rst_req   <= 1'b1;
        cyc(1);
        rst_req <= 1'b0;
        cyc(3);
        chk(32'(running), 32'h0);
        chk(32'(pin_oe_n), 32'hF);
        for (int i = 0; i < 300 && reset_pin_low !== 1'b1; i++) @(posedge ref_clk_i);
        cyc(3);
        chk(32'(straps), 32'h2);
        chk(32'(test_mode), 32'h1);
        chk(32'(running), 32'h1);
        rdc(OFS_GP_CONFIG_ONE, 32'h0);
        rdc(OFS_STRAP_STATUS, 32'h1A);
        rdc(OFS_MAIN_CONFIG_TWO, 32'h1);
        $display("test pin reset done");
        conclude();
    end
endmodule
